// file: src/psm_pkg.sv
// package of constants and carrier types for the power-saving mode controller
// What this block does
// - full stop halts main oscillator, freezes functions, keeps all state
// - port pins keep driving data and direction levels in every mode
// - program counter holds address after the halt instruction during stop
// - halt with timer-wake select at 0 enters full stop
// - stop ends on reset or external interrupt; reset clears registers only
// - interrupt wake vectors if interrupts enabled, else resumes after halt
// - stop release counts interval timer 00 to ff, resumes on overflow
// - rc watchdog enable keeps rc oscillator running through stop
// - with interrupts enabled, watchdog wake gives internal reset if reset select 1, else runs service only if watchdog irq enabled
// - timer mode keeps oscillator; only divide-by-2048 and two timers run
// - halt with timer-wake select at 1 enters wake-up timer mode
// - timer wake works only when that timer is clocked from divide-by-2048
// - wake-up timer mode ends on reset, timer overflow or external interrupt
// - wake-up timer release needs no oscillator stabilisation delay
// - stop wakes on watchdog, irqs, counters, serial; timer mode adds timers
package psm_pkg;

  // clock control register bit positions
  localparam int CKC_TIMER_WAKE_BIT = 6;
  localparam int CKC_RC_WDT_BIT     = 5;
  localparam int CKC_WDT_RESET_BIT  = 4;
  localparam logic [7:0] CKC_RESET  = 8'h00;

  // interval timer start and end counts
  localparam logic [7:0] BIT_START  = 8'h00;
  localparam logic [7:0] BIT_END    = 8'hff;

  // divide ratio of the only prescaler tap alive in wake-up timer mode
  localparam int PRESCALE_DIV       = 2048;

  // number of wake sources: 4 irqs, 2 counters, serial, watchdog, 2 timers
  localparam int NUM_WAKE           = 10;
  localparam int W_IRQ0             = 0;
  localparam int W_EC0              = 4;
  localparam int W_SERIAL           = 6;
  localparam int W_WDT              = 7;
  localparam int W_TMR_A            = 8;
  localparam int W_TMR_C            = 9;

  typedef enum logic [2:0] {
    PSM_RUN    = 3'b000,
    PSM_STOP   = 3'b001,
    PSM_SETTLE = 3'b011,
    PSM_TIMER  = 3'b010,
    PSM_RESUME = 3'b110
  } psm_state_t;

  // what the cpu is told on wake
  typedef struct packed {
    logic resume;
    logic take_irq;
    logic wdt_reset;
  } psm_wake_t;

  // current power state to the clock tree
  typedef struct packed {
    logic main_osc_on;
    logic rc_osc_on;
    logic prescale_on;
    logic timers_on;
    logic cpu_clk_on;
  } psm_clk_t;

endpackage

// file: src/psm_wake_sync.sv
// wake request latch and synchroniser
`timescale 1ns/1ps
module psm_wake_sync #(
  parameter int N = psm_pkg::NUM_WAKE
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] req,
  input  wire logic         clr,
  output logic      [N-1:0] sync
);
  if (N < 1) begin : g_bad_n
    $error("psm_wake_sync needs at least one source");
  end

  logic [N-1:0] held;
  logic [N-1:0] next_held;
  logic [N-1:0] ff1;
  logic [N-1:0] ff2;

  // a request in the clear cycle survives
  always_comb begin
    next_held = (clr ? '0 : held) | req;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= '0;
      ff1  <= '0;
      ff2  <= '0;
    end else begin
      held <= next_held;
      ff1  <= held;
      ff2  <= ff1;
    end
  end

  assign sync = ff2;
endmodule // psm_wake_sync

// file: src/psm_interval_timer.sv
// oscillator stabilisation interval timer
`timescale 1ns/1ps
module psm_interval_timer #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic         tick,
  output logic              overflow,
  output logic      [W-1:0] count
);
  if (W != 8) begin : g_bad_w
    $error("psm_interval_timer counts 8 bits only");
  end

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         run;
  logic         next_run;
  logic         ovf;
  logic         next_ovf;

  always_comb begin
    next_cnt = cnt;
    next_run = run;
    next_ovf = 1'b0;
    if (start) begin
      next_cnt = psm_pkg::BIT_START;
      next_run = 1'b1;
    end else if (run && tick) begin
      if (cnt == psm_pkg::BIT_END) begin
        next_ovf = 1'b1;
        next_run = 1'b0;
        next_cnt = psm_pkg::BIT_START;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= psm_pkg::BIT_START;
      run <= 1'b0;
      ovf <= 1'b0;
    end else begin
      cnt <= next_cnt;
      run <= next_run;
      ovf <= next_ovf;
    end
  end

  assign overflow = ovf;
  assign count    = cnt;
endmodule // psm_interval_timer

// file: src/psm_ctrl.sv
// power-saving mode controller top
`timescale 1ns/1ps
module psm_ctrl #(
  parameter int NW = psm_pkg::NUM_WAKE
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            halt_exec,
  input  wire logic [15:0]     halt_next_pc,
  input  wire logic            irq_global_en,
  input  wire logic            watchdog_irq_enable,
  input  wire logic            stab_tick,
  input  wire logic            timer_a_presc2048,
  input  wire logic            timer_c_presc2048,
  input  wire logic [3:0]      external_irq_inputs,
  input  wire logic [1:0]      event_counter_inputs,
  input  wire logic            serial_wake,
  input  wire logic            watchdog_wake,
  input  wire logic            timer_a_overflow,
  input  wire logic            timer_c_overflow,
  input  wire logic [7:0]      port_data_reg,
  input  wire logic [7:0]      port_dir_reg,
  output logic [7:0]           port_out,
  output logic [7:0]           port_oe,
  output logic [15:0]          hold_pc,
  output psm_pkg::psm_clk_t    clk_ctl,
  output psm_pkg::psm_wake_t   wake,
  output logic                 internal_reset
);
  if (NW != psm_pkg::NUM_WAKE) begin : g_bad_nw
    $error("psm_ctrl wake count fixed");
  end

  localparam logic [11:0] A_CLOCK_CONTROL = 12'h000;
  localparam logic [11:0] A_STATUS        = 12'h004;

  psm_pkg::psm_state_t state;
  psm_pkg::psm_state_t next_state;
  logic [7:0]  clock_control_register;
  logic [7:0]  next_ckc;
  logic [15:0] pc_q;
  logic [15:0] next_pc;
  logic        was_timer;
  logic        next_was_timer;
  psm_pkg::psm_wake_t wake_q;
  psm_pkg::psm_wake_t next_wake;
  logic        irst_q;
  logic        next_irst;
  logic [31:0] rdata_q;
  logic [31:0] next_rdata;

  logic [NW-1:0] raw_wake;
  logic [NW-1:0] sync_wake;
  logic          wake_clr;
  logic          bit_start;
  logic          bit_ovf;
  logic [7:0]    bit_count;
  logic          any_stop_wake;
  logic          any_timer_wake;
  logic          wdt_hit;
  logic          timer_wake_sel;
  logic          rc_wdt_on;
  logic          wr_en;

  assign timer_wake_sel = clock_control_register[psm_pkg::CKC_TIMER_WAKE_BIT];
  assign rc_wdt_on      = clock_control_register[psm_pkg::CKC_RC_WDT_BIT];

  // raw wake requests; timer wake only counts on the 2048 tap
  always_comb begin
    raw_wake = '0;
    raw_wake[psm_pkg::W_IRQ0 +: 4] = external_irq_inputs;
    raw_wake[psm_pkg::W_EC0 +: 2]  = event_counter_inputs;
    raw_wake[psm_pkg::W_SERIAL]    = serial_wake;
    raw_wake[psm_pkg::W_WDT]       = watchdog_wake & rc_wdt_on;
    raw_wake[psm_pkg::W_TMR_A] = timer_a_overflow
                                 & timer_a_presc2048;
    raw_wake[psm_pkg::W_TMR_C] = timer_c_overflow
                                 & timer_c_presc2048;
  end

  psm_wake_sync #(.N(NW)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (raw_wake),
    .clr     (wake_clr),
    .sync    (sync_wake)
  );

  psm_interval_timer #(.W(8)) u_bit (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (bit_start),
    .tick     (stab_tick),
    .overflow (bit_ovf),
    .count    (bit_count)
  );

  assign wdt_hit        = sync_wake[psm_pkg::W_WDT];
  assign any_stop_wake  = |sync_wake[psm_pkg::W_WDT:0];
  assign any_timer_wake = |sync_wake;
  assign wake_clr       = (state == psm_pkg::PSM_RUN);
  assign bit_start      = (state == psm_pkg::PSM_STOP) && any_stop_wake;

  assign wr_en = psel && penable && pwrite;

  // power state sequencer
  always_comb begin
    next_state     = state;
    next_ckc       = clock_control_register;
    next_pc        = pc_q;
    next_was_timer = was_timer;
    next_wake      = '0;
    next_irst      = 1'b0;
    // byte write only; bit ops are software's concern
    if (wr_en && paddr == A_CLOCK_CONTROL && state == psm_pkg::PSM_RUN) begin
      next_ckc = pwdata[7:0];
    end
    unique case (state)
      psm_pkg::PSM_RUN: begin
        if (halt_exec) begin
          next_pc        = halt_next_pc;
          next_was_timer = timer_wake_sel;
          if (timer_wake_sel) begin
            next_state = psm_pkg::PSM_TIMER;
          end else begin
            next_state = psm_pkg::PSM_STOP;
          end
        end
      end
      psm_pkg::PSM_STOP: begin
        if (any_stop_wake) begin
          next_state = psm_pkg::PSM_SETTLE;
        end
      end
      psm_pkg::PSM_SETTLE: begin
        if (bit_ovf) begin
          next_state = psm_pkg::PSM_RESUME;
        end
      end
      psm_pkg::PSM_TIMER: begin
        if (any_timer_wake) begin
          next_state = psm_pkg::PSM_RESUME;
        end
      end
      psm_pkg::PSM_RESUME: begin
        next_state = psm_pkg::PSM_RUN;
        next_wake.resume = 1'b1;
        if (irq_global_en) begin
          if (wdt_hit
              && clock_control_register[psm_pkg::CKC_WDT_RESET_BIT]) begin
            next_irst        = 1'b1;
            next_wake.resume = 1'b0;
            next_ckc         = psm_pkg::CKC_RESET;
          end else if (wdt_hit) begin
            next_wake.take_irq = watchdog_irq_enable;
          end else begin
            next_wake.take_irq = 1'b1;
          end
        end
      end
    endcase
  end

  // register read data
  always_comb begin
    next_rdata = rdata_q;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        A_CLOCK_CONTROL: next_rdata = {24'h000000, clock_control_register};
        A_STATUS:        next_rdata = {10'h000, bit_count, was_timer,
                                       sync_wake, state};
        default:         next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= psm_pkg::PSM_RUN;
      clock_control_register <= psm_pkg::CKC_RESET;
      pc_q                   <= 16'h0000;
      was_timer              <= 1'b0;
      wake_q                 <= '0;
      irst_q                 <= 1'b0;
      rdata_q                <= 32'h00000000;
    end else begin
      state                  <= next_state;
      clock_control_register <= next_ckc;
      pc_q                   <= next_pc;
      was_timer              <= next_was_timer;
      wake_q                 <= next_wake;
      irst_q                 <= next_irst;
      rdata_q                <= next_rdata;
    end
  end

  // clock gating per mode
  always_comb begin
    clk_ctl = '0;
    unique case (state)
      psm_pkg::PSM_STOP: begin
        clk_ctl.rc_osc_on = rc_wdt_on;
      end
      psm_pkg::PSM_SETTLE: begin
        clk_ctl.main_osc_on = 1'b1;
        clk_ctl.rc_osc_on   = rc_wdt_on;
      end
      psm_pkg::PSM_TIMER: begin
        clk_ctl.main_osc_on = 1'b1;
        clk_ctl.prescale_on = 1'b1;
        clk_ctl.timers_on   = 1'b1;
        clk_ctl.rc_osc_on   = rc_wdt_on;
      end
      default: begin
        clk_ctl.main_osc_on = 1'b1;
        clk_ctl.rc_osc_on   = rc_wdt_on;
        clk_ctl.prescale_on = 1'b1;
        clk_ctl.timers_on   = 1'b1;
        clk_ctl.cpu_clk_on  = 1'b1;
      end
    endcase
  end

  assign port_out       = port_data_reg;
  assign port_oe        = port_dir_reg;
  assign hold_pc        = pc_q;
  assign wake           = wake_q;
  assign internal_reset = irst_q;
  assign prdata         = rdata_q;
  assign pready         = psel && penable;
  assign pslverr        = psel && penable && (paddr != A_CLOCK_CONTROL)
                          && (paddr != A_STATUS);
endmodule // psm_ctrl

// file: testbench/psm_ctrl_monitor.sv
// port assertions for the power-saving mode controller
`timescale 1ns/1ps
module psm_ctrl_monitor (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               halt_exec,
  input wire logic [15:0]        halt_next_pc,
  input wire logic               irq_global_en,
  input wire logic               timer_a_presc2048,
  input wire logic               timer_a_overflow,
  input wire logic [7:0]         port_data_reg,
  input wire logic [7:0]         port_dir_reg,
  input wire logic [7:0]         port_out,
  input wire logic [7:0]         port_oe,
  input wire logic [15:0]        hold_pc,
  input wire psm_pkg::psm_clk_t  clk_ctl,
  input wire psm_pkg::psm_wake_t wake,
  input wire logic               internal_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_halt_run;
    halt_exec && clk_ctl.cpu_clk_on;
  endsequence
  sequence s_timer_sleep;
    !clk_ctl.cpu_clk_on && clk_ctl.timers_on && clk_ctl.main_osc_on;
  endsequence
  sequence s_osc_restart;
    !clk_ctl.main_osc_on ##1 clk_ctl.main_osc_on;
  endsequence
  a_port_levels: assert property (
    port_out == port_data_reg && port_oe == port_dir_reg)
    else $error("port levels differ from their registers");
  a_halt_sleeps: assert property (
    s_halt_run |=> !clk_ctl.cpu_clk_on)
    else $error("halt did not gate the cpu clock");
  a_pc_captured: assert property (
    s_halt_run |=> hold_pc == $past(halt_next_pc))
    else $error("held pc is not the address after halt");
  a_pc_held: assert property (
    !clk_ctl.cpu_clk_on && !$past(clk_ctl.cpu_clk_on) |-> $stable(hold_pc))
    else $error("held pc moved while asleep");
  a_stop_frozen: assert property (
    !clk_ctl.main_osc_on && !clk_ctl.cpu_clk_on
      |-> !clk_ctl.timers_on && !clk_ctl.prescale_on)
    else $error("clocks running in full stop");
  a_timer_clocks: assert property (
    clk_ctl.timers_on && !clk_ctl.cpu_clk_on
      |-> clk_ctl.main_osc_on && clk_ctl.prescale_on)
    else $error("timer mode without oscillator or prescaler");
  a_irq_vector: assert property (
    wake.take_irq |-> wake.resume && irq_global_en)
    else $error("vectored with interrupts disabled");
  a_timer_fast: assert property (
    s_timer_sleep ##0 (timer_a_overflow && timer_a_presc2048)
      |-> ##[1:8] wake.resume)
    else $error("timer wake not prompt");
  a_settle_wait: assert property (
    s_osc_restart |-> !wake.resume [*8])
    else $error("resumed before the interval timer ran");
  a_reset_alone: assert property (
    internal_reset |-> !wake.resume)
    else $error("resume together with internal reset");
endmodule // psm_ctrl_monitor

bind psm_ctrl psm_ctrl_monitor psm_ctrl_monitor_inst (.*);

// file: testbench/psm_cpu_model.sv
// cpu and prescaler model facing the power-saving controller
`timescale 1ns/1ps
module psm_cpu_model #(
  parameter logic [15:0] NEXT_PC = 16'h0c42
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        halt_cmd,
  output logic             halt_exec,
  output logic [15:0]      halt_next_pc,
  output logic             stab_tick
);
  // clock is an external crystal, never the internal oscillator
  assign halt_next_pc = NEXT_PC;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_exec <= 1'b0;
      stab_tick <= 1'b0;
    end else begin
      // one halt, then no-operation slots before the next
      halt_exec <= halt_cmd && !halt_exec;
      // short tick period stands in for the slow ratio software picks
      stab_tick <= !stab_tick;
    end
  end
endmodule // psm_cpu_model

// file: testbench/tb_power_saving_mode_control.sv
// self-checking bench for the power-saving mode controller
`timescale 1ns/1ps
module tb_power_saving_mode_control;
  localparam logic [15:0] PC = 16'h0c42;
  logic               pclk, presetn, psel, penable, pwrite, pready, err;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               halt_cmd, halt_exec, stab_tick, ien, pslverr, irst;
  logic               wie;
  logic [1:0]         tap;
  logic [15:0]        next_pc, hold_pc;
  logic [9:0]         src;
  logic [7:0]         pdat, pdir, port_out, port_oe;
  psm_pkg::psm_clk_t  clk_ctl;
  psm_pkg::psm_wake_t wake;
  int                 n_mismatch, checked, cyc;
  psm_cpu_model #(.NEXT_PC(PC)) psm_cpu_model_inst (.pclk(pclk),
    .presetn(presetn), .halt_cmd(halt_cmd), .halt_exec(halt_exec),
    .halt_next_pc(next_pc), .stab_tick(stab_tick));
  psm_ctrl psm_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_exec(halt_exec), .halt_next_pc(next_pc), .irq_global_en(ien),
    .watchdog_irq_enable(wie), .stab_tick(stab_tick),
    .timer_a_presc2048(tap[0]), .timer_c_presc2048(tap[1]),
    .external_irq_inputs(src[3:0]), .event_counter_inputs(src[5:4]),
    .serial_wake(src[6]), .watchdog_wake(src[7]),
    .timer_a_overflow(src[8]), .timer_c_overflow(src[9]),
    .port_data_reg(pdat), .port_dir_reg(pdir), .port_out(port_out),
    .port_oe(port_oe), .hold_pc(hold_pc), .clk_ctl(clk_ctl),
    .wake(wake), .internal_reset(irst));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 8);
    if (i >= 8) chk("pready", 1, 0);
    if (i >= 8) tally_and_finish();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // halt with a clock control byte, then check the sleeping state
  task automatic enter(input logic [7:0] ckc, input logic ie);
    apb(1'b1, 12'h000, ckc);
    ien <= ie;
    halt_cmd <= 1'b1;
    @(posedge pclk);
    halt_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("clocks", {ckc[6:5], 1'b0}, {clk_ctl.main_osc_on,
        clk_ctl.rc_osc_on, clk_ctl.cpu_clk_on});
    chk("pc", PC, hold_pc);
    chk("ports", {pdat, pdir}, {port_out, port_oe});
    apb(1'b0, 12'h004, 0);
    chk("mode", ckc[6] ? 32'h2002 : 32'h1, rd);
    apb(1'b1, 12'h000, ~ckc);
  endtask
  task automatic kick(input logic [9:0] m);
    src <= m;
    @(posedge pclk);
    src <= 10'h0;
  endtask
  // ew = {reset, irq}; a wait that runs out ends the run
  task automatic wait_wake(input int lo, hi, input logic [1:0] ew);
    cyc = 1;
    while (wake.resume !== 1'b1 && irst !== 1'b1 && cyc < 1000) begin
      @(posedge pclk);
      cyc++;
    end
    chk("delay", 1, cyc >= lo && cyc <= hi);
    chk("wake", ew, {irst, wake.take_irq});
    if (cyc >= 1000) tally_and_finish();
    @(posedge pclk);
  endtask
  task automatic sleep(input logic [7:0] ckc, input int s, input logic ie,
                       input int lo, hi, input logic [1:0] ew);
    enter(ckc, ie);
    kick(10'h1 << s);
    wait_wake(lo, hi, ew);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, halt_cmd, ien, src} = '0;
    pdat = 8'ha5;
    pdir = 8'h3c;
    wie = 1'b1;
    tap = 2'b11;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 12'h008, 0);
    chk("unmapped", 32'h8000_0000, {err, rd[30:0]});
    for (int s = 0; s < 7; s++)
      sleep(8'h10, s, s[0], 500, 600, {1'b0, s[0]});
    apb(1'b0, 12'h000, 0);
    chk("ctrl kept", 32'h10, rd);
    for (int s = 0; s < 3; s++)
      sleep(8'h40, s ? s + 7 : 0, s[0], 1, 8, {1'b0, s[0]});
    apb(1'b0, 12'h000, 0);
    chk("ctrl timer", 32'h40, rd);
    tap <= 2'b00;
    enter(8'h40, 1'b0);
    kick(10'h300);
    repeat (8) @(posedge pclk);
    apb(1'b0, 12'h004, 0);
    chk("tap gate", 32'h2002, rd);
    tap <= 2'b11;
    kick(10'h001);
    wait_wake(1, 8, 2'b00);
    enter(8'h10, 1'b0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset wake", 1, clk_ctl.cpu_clk_on);
    apb(1'b0, 12'h000, 0);
    chk("ctrl reset wake", 32'h0, rd);
    sleep(8'h20, 7, 1'b1, 500, 600, 2'b01);
    sleep(8'h20, 7, 1'b0, 500, 600, 2'b00);
    wie <= 1'b0;
    sleep(8'h20, 7, 1'b1, 500, 600, 2'b00);
    sleep(8'h30, 7, 1'b1, 500, 600, 2'b10);
    apb(1'b0, 12'h000, 0);
    chk("ctrl cleared", 32'h0, rd);
    tally_and_finish();
  end
endmodule // tb_power_saving_mode_control
